/* core/afe_slot_ctrl_consts.vh */
// Constants for the per-slot front-end control block
`ifndef AFE_SLOT_CTRL_CONSTS_VH
`define AFE_SLOT_CTRL_CONSTS_VH

// ==========================================================
// Clock and timing
`define CLK_PERIOD_NS 8
`define CYC_PER_US (1000 / `CLK_PERIOD_NS)
`define PRE_WIDTH_US 8
`define PRE_WIDTH_RST 8'h08

// ==========================================================
// Slots and sampling modes
`define NUM_SLOTS 12
`define MODE_STD 2'h0
`define MODE_DINT 2'h1
`define MODE_IMP 2'h2
`define MODE_TADC 2'h3

// ==========================================================
// LED driver sides and currents (tenths of a mA)
`define SIDE_A 2'h1
`define SIDE_B 2'h2
`define LED_MIN_TENTHS 13'h00f
`define LED_STEP_NUM 13'h03f
`define LED_LIMIT_TENTHS 13'hfa0

// ==========================================================
// Input bias selection codes
`define BIAS_IDLE 4'h8
`define BIAS_OFF 4'hf
`define PRE_PAIR_SHORT 3'h6

`endif

/* core/afe_slot_ctrl.v */
// Slot control: input routing, bias, LED limiter and accumulators
`timescale 1ns/1ps
`include "afe_slot_ctrl_consts.vh"

// Function
// - Each pair's differential select applies in every active slot.
// - Per slot route field enables a pair and picks its channel mapping.
// - Inputs not enabled sit in the pair's idle bias state.
// - Inputs are active only in precondition and pulse regions.
// - Per slot precondition picks one of seven bias options.
// - Precondition opens each slot; width per slot, default 8 us.
// - Bias connections drop off during sampling of enabled inputs.
// - Channel two off after reset; powered down, no conversions.
// - Integration and impulse modes never use channel two.
// - Per slot bit runs channel two conversions and datapath.
// - Channel one results are issued before channel two results.
// - Channel two front-end settings held apart from channel one.
// - Up to four drivers per slot, only one side of each.
// - Seven-bit monotonic current code, 1.5 mA to 200 mA.
// - Current code zero disables the driver in that slot.
// - Above 400 mA, drivers one to four take current in order.
// - Both driver sides are configurable, even the unpinned one.
// - Positive and negative sums are 32-bit saturating unsigned.
// - Samples go by negate mask, or lit and dark region.
// - Impulse mode sums in the positive sum, passed straight out.
// - Signal is positive minus negative, clipped at zero.
// - Both pairs have identical per slot routing logic.
module afe_slot_ctrl (
    // Clock and reset
    input wire clk_i,
    input wire resetn_i,
    // Slot sequencer
    input wire slot_start_i,
    input wire [3:0] slot_idx_i,
    input wire slot_end_i,
    input wire device_sleep_i,
    input wire pulse_region_i,
    input wire [3:0] pulse_num_i,
    input wire lit_region_i,
    input wire [1:0] mode_i,
    // Converter samples
    input wire adc_valid_i,
    input wire adc_ch2_i,
    input wire [13:0] adc_data_i,
    // Input pair configuration
    input wire first_pair_diff_select_i,
    input wire second_pair_diff_select_i,
    input wire [23:0] first_pair_slot_route_i,
    input wire [23:0] second_pair_slot_route_i,
    input wire [1:0] first_pair_idle_state_i,
    input wire [1:0] second_pair_idle_state_i,
    input wire [35:0] slot_precharge_select_i,
    // Precondition width write
    input wire pre_width_we_i,
    input wire [3:0] pre_width_slot_i,
    input wire [7:0] pre_width_us_i,
    // Channel settings
    input wire [11:0] slot_second_channel_on_i,
    input wire [6:0] ch1_afe_cfg_i,
    input wire [6:0] ch2_afe_cfg_i,
    // LED configuration
    input wire [23:0] slot_driver_a_side_i,
    input wire [23:0] slot_driver_b_side_i,
    input wire [23:0] slot_driver_c_side_i,
    input wire [23:0] slot_driver_d_side_i,
    input wire [83:0] slot_driver_a_current_i,
    input wire [83:0] slot_driver_b_current_i,
    input wire [83:0] slot_driver_c_current_i,
    input wire [83:0] slot_driver_d_current_i,
    input wire [191:0] pulse_negate_mask_i,
    // Input switch control
    output reg [2:0] first_pair_conn_o,
    output reg [2:0] second_pair_conn_o,
    output reg [3:0] first_pair_bias_o,
    output reg [3:0] second_pair_bias_o,
    output wire precon_active_o,
    // Channel control
    output reg [6:0] ch1_afe_cfg_o,
    output reg [6:0] ch2_afe_cfg_o,
    output reg ch2_power_o,
    // LED sinks
    output reg sink_output_one_o,
    output reg sink_output_two_o,
    output reg sink_output_three_o,
    output reg sink_output_four_o,
    output reg [3:0] sink_side_b_o,
    output reg [27:0] drive_code_o,
    // Slot results
    output reg result_valid_o,
    output reg result_ch2_o,
    output reg [3:0] result_slot_o,
    output reg [31:0] result_signal_o,
    output reg [31:0] result_dark_o
);

    // ==========================================================
    // Helper functions
    // Current in tenths of a mA for a drive code
    function [12:0] cur_of;
        input [6:0] c;
        begin
            if (c == 7'h00) begin
                cur_of = 13'h000;
            end else begin
                cur_of = `LED_MIN_TENTHS +
                    ((({6'h00, c} - 13'h001) * `LED_STEP_NUM) >> 2);
            end
        end
    endfunction

    // Largest code whose current fits in a remaining budget
    function [6:0] code_of;
        input [12:0] r;
        reg [14:0] t;
        begin
            t = (({2'h0, r} - {2'h0, `LED_MIN_TENTHS}) << 2) + 15'h0003;
            t = (t / 15'h003f) + 15'h0001;
            if (r < `LED_MIN_TENTHS) begin
                code_of = 7'h00;
            end else begin
                code_of = t[6:0];
            end
        end
    endfunction

    // Saturating add of one sample to a sum
    function [31:0] sat_add;
        input [31:0] a;
        input [13:0] b;
        reg [32:0] s;
        begin
            s = {1'b0, a} + {19'h00000, b};
            sat_add = s[32] ? 32'hffffffff : s[31:0];
        end
    endfunction

    // ==========================================================
    // Latched slot state
    reg in_slot;
    reg [3:0] slot;
    reg [1:0] mode;
    reg ch2_on;
    reg [1:0] route [0:1];
    reg [2:0] pre_sel;
    reg [15:0] neg_mask;
    reg [6:0] grant [0:3];
    reg [1:0] side [0:3];
    reg [7:0] pre_width [0:11];
    reg [7:0] us_left;
    reg [6:0] cyc;
    reg [31:0] pos1, neg1, pos2, neg2;
    reg pend2;
    integer i, j;

    wire [95:0] side_all = {slot_driver_d_side_i, slot_driver_c_side_i,
        slot_driver_b_side_i, slot_driver_a_side_i};
    wire [335:0] cur_all = {slot_driver_d_current_i,
        slot_driver_c_current_i, slot_driver_b_current_i,
        slot_driver_a_current_i};
    wire [47:0] route_all = {second_pair_slot_route_i,
        first_pair_slot_route_i};
    wire [3:0] idle_all = {second_pair_idle_state_i,
        first_pair_idle_state_i};
    wire [1:0] diff_all = {second_pair_diff_select_i,
        first_pair_diff_select_i};

    // ==========================================================
    // Current limiter on the slot being started
    reg [6:0] next_grant [0:3];
    reg [1:0] next_side [0:3];
    reg [12:0] rem;
    reg [12:0] need;
    reg [6:0] req;
    always @* begin
        rem = `LED_LIMIT_TENTHS;
        for (j = 0; j < 4; j = j + 1) begin
            next_side[j] = side_all[j*24 + slot_idx_i*2 +: 2];
            req = cur_all[j*84 + slot_idx_i*7 +: 7];
            // Both sides at once is refused: driver stays off
            if (next_side[j] != `SIDE_A && next_side[j] != `SIDE_B) begin
                req = 7'h00;
            end
            need = cur_of(req);
            if (need <= rem) begin
                next_grant[j] = req;
            end else begin
                next_grant[j] = code_of(rem);
            end
            rem = rem - cur_of(next_grant[j]);
        end
    end

    // ==========================================================
    // Slot latch and precondition timer
    assign precon_active_o = in_slot && (us_left != 8'h00);

    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            in_slot <= 1'b0;
            slot <= 4'h0;
            mode <= `MODE_STD;
            ch2_on <= 1'b0;
            route[0] <= 2'h0;
            route[1] <= 2'h0;
            pre_sel <= 3'h0;
            neg_mask <= 16'h0000;
            us_left <= 8'h00;
            cyc <= 7'h00;
            for (i = 0; i < 4; i = i + 1) begin
                grant[i] <= 7'h00;
                side[i] <= 2'h0;
            end
            for (i = 0; i < `NUM_SLOTS; i = i + 1) begin
                pre_width[i] <= `PRE_WIDTH_RST;
            end
        end else begin
            if (pre_width_we_i && pre_width_slot_i < `NUM_SLOTS) begin
                pre_width[pre_width_slot_i] <= pre_width_us_i;
            end
            if (slot_start_i && slot_idx_i < `NUM_SLOTS) begin
                in_slot <= 1'b1;
                slot <= slot_idx_i;
                mode <= mode_i;
                ch2_on <= slot_second_channel_on_i[slot_idx_i];
                route[0] <= route_all[slot_idx_i*2 +: 2];
                route[1] <= route_all[24 + slot_idx_i*2 +: 2];
                pre_sel <= slot_precharge_select_i[slot_idx_i*3 +: 3];
                neg_mask <= pulse_negate_mask_i[slot_idx_i*16 +: 16];
                us_left <= pre_width[slot_idx_i];
                cyc <= 7'h00;
                for (i = 0; i < 4; i = i + 1) begin
                    grant[i] <= next_grant[i];
                    side[i] <= next_side[i];
                end
            end else begin
                if (slot_end_i) begin
                    in_slot <= 1'b0;
                end
                if (us_left != 8'h00) begin
                    if (cyc == `CYC_PER_US - 1) begin
                        cyc <= 7'h00;
                        us_left <= us_left - 8'h01;
                    end else begin
                        cyc <= cyc + 7'h01;
                    end
                end
            end
        end
    end

    // ==========================================================
    // Input switch matrices, one per pair
    genvar p;
    generate
        for (p = 0; p < 2; p = p + 1) begin : g_pair
            wire en = in_slot && (route[p] != 2'h0);
            wire act = en && !device_sleep_i &&
                (precon_active_o || pulse_region_i);
            reg [2:0] conn;
            reg [3:0] bias;
            always @* begin
                if (act) begin
                    conn = {diff_all[p], route[p]};
                end else begin
                    conn = 3'h0;
                end
                if (!act) begin
                    bias = `BIAS_IDLE | {2'h0, idle_all[p*2 +: 2]};
                end else if (precon_active_o) begin
                    bias = (pre_sel > `PRE_PAIR_SHORT) ? 4'h0 :
                        {1'b0, pre_sel};
                end else begin
                    bias = `BIAS_OFF;
                end
            end
        end
    endgenerate

    // Register the switch controls
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            first_pair_conn_o <= 3'h0;
            second_pair_conn_o <= 3'h0;
            first_pair_bias_o <= `BIAS_IDLE;
            second_pair_bias_o <= `BIAS_IDLE;
        end else begin
            first_pair_conn_o <= g_pair[0].conn;
            second_pair_conn_o <= g_pair[1].conn;
            first_pair_bias_o <= g_pair[0].bias;
            second_pair_bias_o <= g_pair[1].bias;
        end
    end

    // ==========================================================
    // Channel two gating and LED sink drive
    wire ch2_act = in_slot && ch2_on &&
        (mode == `MODE_STD || mode == `MODE_TADC);
    wire fire = in_slot && pulse_region_i && !device_sleep_i;

    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ch1_afe_cfg_o <= 7'h00;
            ch2_afe_cfg_o <= 7'h00;
            ch2_power_o <= 1'b0;
            sink_output_one_o <= 1'b0;
            sink_output_two_o <= 1'b0;
            sink_output_three_o <= 1'b0;
            sink_output_four_o <= 1'b0;
            sink_side_b_o <= 4'h0;
            drive_code_o <= 28'h0000000;
        end else begin
            ch1_afe_cfg_o <= ch1_afe_cfg_i;
            ch2_afe_cfg_o <= ch2_act ? ch2_afe_cfg_i : 7'h00;
            ch2_power_o <= ch2_act;
            sink_output_one_o <= fire && side[0] == `SIDE_A &&
                grant[0] != 7'h00;
            sink_output_two_o <= fire && side[1] == `SIDE_A &&
                grant[1] != 7'h00;
            sink_output_three_o <= fire && side[2] == `SIDE_A &&
                grant[2] != 7'h00;
            sink_output_four_o <= fire && side[3] == `SIDE_A &&
                grant[3] != 7'h00;
            for (i = 0; i < 4; i = i + 1) begin
                sink_side_b_o[i] <= fire && side[i] == `SIDE_B &&
                    grant[i] != 7'h00;
            end
            drive_code_o <= {grant[3], grant[2], grant[1], grant[0]};
        end
    end

    // ==========================================================
    // Accumulators and result issue
    wire to_neg = (mode == `MODE_DINT) ? !lit_region_i :
        (mode == `MODE_IMP) ? 1'b0 : neg_mask[pulse_num_i];
    wire take1 = in_slot && adc_valid_i && !adc_ch2_i;
    wire take2 = in_slot && adc_valid_i && adc_ch2_i && ch2_act;
    wire [31:0] sig1 = (mode == `MODE_IMP) ? pos1 :
        (pos1 > neg1 ? pos1 - neg1 : 32'h00000000);
    wire [31:0] sig2 = pos2 > neg2 ? pos2 - neg2 : 32'h00000000;

    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pos1 <= 32'h00000000;
            neg1 <= 32'h00000000;
            pos2 <= 32'h00000000;
            neg2 <= 32'h00000000;
            pend2 <= 1'b0;
            result_valid_o <= 1'b0;
            result_ch2_o <= 1'b0;
            result_slot_o <= 4'h0;
            result_signal_o <= 32'h00000000;
            result_dark_o <= 32'h00000000;
        end else begin
            result_valid_o <= 1'b0;
            if (slot_start_i) begin
                pos1 <= 32'h00000000;
                neg1 <= 32'h00000000;
                pos2 <= 32'h00000000;
                neg2 <= 32'h00000000;
            end else begin
                if (take1 && !to_neg) pos1 <= sat_add(pos1, adc_data_i);
                if (take1 && to_neg) neg1 <= sat_add(neg1, adc_data_i);
                if (take2 && !to_neg) pos2 <= sat_add(pos2, adc_data_i);
                if (take2 && to_neg) neg2 <= sat_add(neg2, adc_data_i);
            end
            // Channel one first, channel two on the following cycle
            if (in_slot && slot_end_i) begin
                result_valid_o <= 1'b1;
                result_ch2_o <= 1'b0;
                result_slot_o <= slot;
                result_signal_o <= sig1;
                result_dark_o <= (mode == `MODE_IMP) ? 32'h0 : neg1;
                pend2 <= ch2_act;
            end else if (pend2) begin
                pend2 <= 1'b0;
                result_valid_o <= 1'b1;
                result_ch2_o <= 1'b1;
                result_signal_o <= sig2;
                result_dark_o <= neg2;
            end
        end
    end

endmodule // afe_slot_ctrl

/* verif/sense_source.sv */
// Converter sample source standing in for the sensor side
`timescale 1ns/1ps
module sense_source (
    // Clock and reset
    input wire clk_i,
    input wire resetn_i,
    // Bench request
    input wire req_i,
    input wire ch2_i,
    input wire [13:0] data_i,
    input wire pulse_region_i,
    // Converter output
    output reg adc_valid_o,
    output reg adc_ch2_o,
    output reg [13:0] adc_data_o
);
    // ========
    // Samples only inside the pulse region; idle data keeps changing
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            adc_valid_o <= 1'h0;
            adc_ch2_o <= 1'h0;
            adc_data_o <= 14'h0000;
        end else begin
            adc_valid_o <= req_i && pulse_region_i;
            adc_ch2_o <= ch2_i;
            adc_data_o <= req_i ? data_i : ~adc_data_o;
        end
    end
endmodule // sense_source

/* verif/afe_slot_ctrl_properties.sv */
// Concurrent checks on the slot control ports
`timescale 1ns/1ps
`include "afe_slot_ctrl_consts.vh"
module afe_slot_ctrl_properties (
    // Clock, reset and sequencer
    input wire clk_i,
    input wire resetn_i,
    input wire slot_start_i,
    input wire slot_end_i,
    input wire device_sleep_i,
    input wire pulse_region_i,
    input wire [1:0] first_pair_idle_state_i,
    // Observed outputs
    input wire precon_active_o,
    input wire [2:0] first_pair_conn_o,
    input wire [3:0] first_pair_bias_o,
    input wire [6:0] ch2_afe_cfg_o,
    input wire ch2_power_o,
    input wire sink_output_one_o,
    input wire [3:0] sink_side_b_o,
    input wire [27:0] drive_code_o,
    input wire result_valid_o,
    input wire result_ch2_o
);
    // ========
    // One clock domain
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);
    // ========
    // Sequencing and results
    chk_precon_cause: assert property (
        $rose(precon_active_o) |-> $past(slot_start_i))
        else $error("precondition without slot start");
    chk_ch2_order: assert property (
        result_valid_o && result_ch2_o |->
        $past(result_valid_o) && !$past(result_ch2_o))
        else $error("channel two result not after channel one");
    chk_result_cause: assert property (
        result_valid_o && !result_ch2_o |-> $past(slot_end_i))
        else $error("result without slot end");
    chk_ch2_power: assert property (
        $past(ch2_afe_cfg_o) != 7'h00 && ch2_afe_cfg_o != 7'h00
        |-> ch2_power_o)
        else $error("channel two settings while powered down");
    // ========
    // LED sinks
    chk_sink_region: assert property (
        sink_output_one_o |-> $past(pulse_region_i)
        || $past(pulse_region_i, 2))
        else $error("sink on outside pulse region");
    chk_side_excl: assert property (
        sink_output_one_o |-> !sink_side_b_o[0])
        else $error("both sides of driver one on");
    chk_code_zero: assert property (
        sink_output_one_o |-> drive_code_o[6:0] != 7'h00)
        else $error("sink on with zero code");
    // ========
    // Input bias
    chk_idle_bias: assert property (
        $past(resetn_i) && $past(device_sleep_i)
        && $stable(first_pair_idle_state_i) |-> first_pair_bias_o
        == (`BIAS_IDLE | {2'h0, first_pair_idle_state_i}))
        else $error("sleep bias differs from idle state");
    chk_precon_bias: assert property (
        precon_active_o && $past(precon_active_o)
        && first_pair_conn_o != 3'h0 |-> first_pair_bias_o <= 4'h6)
        else $error("precondition bias out of range");
    chk_sample_bias: assert property (
        $past(pulse_region_i, 2) && $past(pulse_region_i)
        && first_pair_conn_o != 3'h0 |-> first_pair_bias_o == `BIAS_OFF)
        else $error("bias connected while sampling");
    // ========
    // Main scenarios
    cover property (result_valid_o && result_ch2_o);
    cover property ($fell(precon_active_o));
    cover property (sink_output_one_o);
endmodule // afe_slot_ctrl_properties

bind afe_slot_ctrl afe_slot_ctrl_properties i_props (.clk_i, .resetn_i,
    .slot_start_i, .slot_end_i, .device_sleep_i, .pulse_region_i,
    .first_pair_idle_state_i, .precon_active_o, .first_pair_conn_o,
    .first_pair_bias_o, .ch2_afe_cfg_o, .ch2_power_o, .sink_output_one_o,
    .sink_side_b_o, .drive_code_o, .result_valid_o, .result_ch2_o);

/* verif/afe_slot_ctrl_tb.sv */
// Self-checking bench for the slot control block
`timescale 1ns/1ps
`include "afe_slot_ctrl_consts.vh"
module afe_slot_ctrl_tb;
    // ========
    // Stimulus, configuration and observed outputs
    logic clk_i, resetn_i, slot_start_i, slot_end_i, device_sleep_i;
    logic pulse_region_i, lit_region_i, pre_width_we_i, req, req_ch2;
    logic second_pair_diff_select_i, first_pair_diff_select_i = 1'h1;
    logic [13:0] req_data;
    logic [3:0] slot_idx_i, pulse_num_i, pre_width_slot_i;
    logic [1:0] mode_i;
    logic [7:0] pre_width_us_i;
    logic [23:0] first_pair_slot_route_i = 24'h1;
    logic [23:0] second_pair_slot_route_i = 24'h0;
    logic [1:0] first_pair_idle_state_i = 2'h2;
    logic [1:0] second_pair_idle_state_i = 2'h1;
    logic [35:0] slot_precharge_select_i = 36'h3;
    logic [11:0] slot_second_channel_on_i = 12'h006;
    logic [6:0] ch1_afe_cfg_i = 7'h15;
    logic [6:0] ch2_afe_cfg_i = 7'h2a;
    logic [23:0] slot_driver_a_side_i = 24'h5;
    logic [23:0] slot_driver_b_side_i = 24'h5;
    logic [23:0] slot_driver_c_side_i = 24'h6;
    logic [23:0] slot_driver_d_side_i = 24'h4;
    logic [83:0] slot_driver_a_current_i = 84'h2f80;
    logic [83:0] slot_driver_b_current_i = 84'h2f94;
    logic [83:0] slot_driver_c_current_i = 84'h2f9e;
    logic [83:0] slot_driver_d_current_i = 84'h500;
    logic [191:0] pulse_negate_mask_i = 192'h20002;
    wire adc_valid_i, adc_ch2_i, precon_active_o, ch2_power_o;
    wire [13:0] adc_data_i;
    wire [2:0] first_pair_conn_o, second_pair_conn_o;
    wire [3:0] first_pair_bias_o, second_pair_bias_o, sink_side_b_o;
    wire [3:0] result_slot_o;
    wire [6:0] ch1_afe_cfg_o, ch2_afe_cfg_o;
    wire sink_output_one_o, sink_output_two_o, sink_output_three_o;
    wire sink_output_four_o, result_valid_o, result_ch2_o;
    wire [27:0] drive_code_o;
    wire [31:0] result_signal_o, result_dark_o;
    integer num_errors = 0, compares = 0;
    integer cycles = 0;

    afe_slot_ctrl i_dut (.clk_i, .resetn_i, .slot_start_i, .slot_idx_i,
        .slot_end_i, .device_sleep_i, .pulse_region_i, .pulse_num_i,
        .lit_region_i, .mode_i, .adc_valid_i, .adc_ch2_i, .adc_data_i,
        .first_pair_diff_select_i, .second_pair_diff_select_i,
        .first_pair_slot_route_i, .second_pair_slot_route_i,
        .first_pair_idle_state_i, .second_pair_idle_state_i,
        .slot_precharge_select_i, .pre_width_we_i, .pre_width_slot_i,
        .pre_width_us_i, .slot_second_channel_on_i, .ch1_afe_cfg_i,
        .ch2_afe_cfg_i, .slot_driver_a_side_i, .slot_driver_b_side_i,
        .slot_driver_c_side_i, .slot_driver_d_side_i,
        .slot_driver_a_current_i, .slot_driver_b_current_i,
        .slot_driver_c_current_i, .slot_driver_d_current_i,
        .pulse_negate_mask_i, .first_pair_conn_o, .second_pair_conn_o,
        .first_pair_bias_o, .second_pair_bias_o, .precon_active_o,
        .ch1_afe_cfg_o, .ch2_afe_cfg_o, .ch2_power_o, .sink_output_one_o,
        .sink_output_two_o, .sink_output_three_o, .sink_output_four_o,
        .sink_side_b_o, .drive_code_o, .result_valid_o, .result_ch2_o,
        .result_slot_o, .result_signal_o, .result_dark_o);
    sense_source i_src (.clk_i, .resetn_i, .req_i(req), .ch2_i(req_ch2),
        .data_i(req_data), .pulse_region_i, .adc_valid_o(adc_valid_i),
        .adc_ch2_o(adc_ch2_i), .adc_data_o(adc_data_i));

    // ========
    // Clock and cycle ceiling
    always #4 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles = cycles + 1;
        if (cycles == 10000) begin
            num_errors = num_errors + 1;
            conclude;
        end
    end

    // ========
    // Helpers
    task tick;
        @(posedge clk_i);
        #1;
    endtask
    task check(input logic [31:0] got, input logic [31:0] exp);
        compares = compares + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("CHECK FAILED at %0t: got %h, expected %h",
                $time, got, exp);
        end
    endtask
    // Drive current in tenths of a mA for a code
    function automatic integer cur(input integer k);
        cur = (k == 0) ? 0 : 15 + (k - 1) * 63 / 4;
    endfunction
    // Granted codes, drivers one to four in order within 400 mA
    function automatic logic [31:0] limit(input logic [3:0] s);
        integer i, k, left;
        logic [27:0] ask;
        ask = {slot_driver_d_current_i[7*s +: 7],
            slot_driver_c_current_i[7*s +: 7],
            slot_driver_b_current_i[7*s +: 7],
            slot_driver_a_current_i[7*s +: 7]};
        left = 4000;
        limit = 32'h0;
        for (i = 0; i < 4; i = i + 1) begin
            k = ask[7*i +: 7];
            while (k > 0 && cur(k) > left)
                k = k - 1;
            limit[7*i +: 7] = k[6:0];
            left = left - cur(k);
        end
    endfunction
    task pulse(input logic [3:0] n, input logic ch2, input logic [13:0] d);
        pulse_num_i = n;
        req = 1'h1;
        req_ch2 = ch2;
        req_data = d;
        tick;
        req = 1'h0;
        repeat (2) tick;
    endtask
    // Start a slot, time the precondition, enter the pulse region
    task start(input logic [3:0] s, input logic [1:0] m,
        input integer pre, input logic [3:0] pbias);
        integer n;
        n = 0;
        mode_i = m;
        slot_idx_i = s;
        slot_start_i = 1'h1;
        tick;
        slot_start_i = 1'h0;
        while (precon_active_o === 1'h1 && n < 2000) begin
            if (n == 4) check(first_pair_bias_o, pbias);
            n = n + 1;
            tick;
        end
        check(n, pre);
        pulse_region_i = 1'h1;
        repeat (2) tick;
    endtask
    task finish(input logic [3:0] s, input logic v,
        input logic [31:0] sig, input logic [31:0] dark, input logic v2);
        pulse_region_i = 1'h0;
        slot_end_i = 1'h1;
        tick;
        slot_end_i = 1'h0;
        check({result_valid_o, result_ch2_o}, {v, 1'h0});
        if (v) check(result_slot_o, s);
        if (v) check(result_signal_o, sig);
        if (v) check(result_dark_o, dark);
        tick;
        check({result_valid_o, result_ch2_o}, {v2, v2});
    endtask
    task conclude;
        $display("Comparisons %0d, mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ========
    // Test sequence
    initial begin
        {clk_i, resetn_i, slot_start_i, slot_end_i, device_sleep_i,
            pulse_region_i, lit_region_i, pre_width_we_i, req, req_ch2,
            second_pair_diff_select_i} = 11'h0;
        {req_data, slot_idx_i, pulse_num_i, pre_width_slot_i, mode_i,
            pre_width_us_i} = 36'h0;
        repeat (4) tick;
        resetn_i = 1'h1;
        tick;
        check({ch2_power_o, first_pair_bias_o}, 5'h0a);
        device_sleep_i = 1'h1;
        first_pair_idle_state_i = 2'h1;
        repeat (2) tick;
        check(first_pair_bias_o, 4'h9);
        first_pair_idle_state_i = 2'h2;
        device_sleep_i = 1'h0;
        // Standard slot within the current budget, channel two off
        start(4'h0, `MODE_STD, 1000, 4'h3);
        check(first_pair_conn_o, 3'h5);
        check(first_pair_bias_o, `BIAS_OFF);
        check(second_pair_bias_o, 4'h9);
        check({sink_output_two_o, sink_output_one_o}, 2'h2);
        check(sink_side_b_o, 4'h4);
        check(drive_code_o, limit(4'h0));
        pulse(4'h0, 1'h0, 14'h0064);
        pulse(4'h1, 1'h0, 14'h001e);
        pulse(4'h0, 1'h1, 14'h0032);
        finish(4'h0, 1'h1, 32'h46, 32'h1e, 1'h0);
        // Short precondition, over-budget currents, both channels
        pre_width_slot_i = 4'h1;
        pre_width_us_i = 8'h02;
        pre_width_we_i = 1'h1;
        tick;
        pre_width_we_i = 1'h0;
        start(4'h1, `MODE_STD, 250, 4'ha);
        check(drive_code_o, limit(4'h1));
        check({sink_output_four_o, sink_output_three_o, sink_output_two_o,
            sink_output_one_o}, 4'h7);
        check({ch2_power_o, ch2_afe_cfg_o, ch1_afe_cfg_o}, 15'h5515);
        check({first_pair_conn_o, first_pair_bias_o}, 7'h0a);
        pulse(4'h0, 1'h0, 14'h000a);
        pulse(4'h1, 1'h0, 14'h0028);
        pulse(4'h0, 1'h1, 14'h012c);
        finish(4'h1, 1'h1, 32'h0, 32'h28, 1'h1);
        check(result_signal_o, 32'h12c);
        // Impulse mode leaves channel two unused
        start(4'h2, `MODE_IMP, 1000, 4'ha);
        check(ch2_power_o, 1'h0);
        pulse(4'h0, 1'h0, 14'h0005);
        pulse(4'h1, 1'h0, 14'h0007);
        pulse(4'h0, 1'h1, 14'h0009);
        finish(4'h2, 1'h1, 32'hc, 32'h0, 1'h0);
        // Integration mode sorts by lit and dark region
        start(4'h3, `MODE_DINT, 1000, 4'ha);
        lit_region_i = 1'h1;
        pulse(4'h0, 1'h0, 14'h0032);
        lit_region_i = 1'h0;
        pulse(4'h1, 1'h0, 14'h0014);
        finish(4'h3, 1'h1, 32'h1e, 32'h14, 1'h0);
        // Slot number beyond the last is refused
        start(4'hc, `MODE_STD, 0, 4'ha);
        finish(4'hc, 1'h0, 32'h0, 32'h0, 1'h0);
        conclude;
    end
endmodule // afe_slot_ctrl_tb
